//--- inc/irqfe_pkg.sv
// shared constants of the interrupt source front end
package irqfe_pkg;
  localparam int ADDR_W = 20;
  localparam int EXT_N = 6;
  localparam int KEY_N = 4;
  localparam int MATCH_N = 4;
  localparam int APB_AW = 8;
  // register byte offsets
  localparam logic [7:0] OFS_CAUSE = 8'h00;
  localparam logic [7:0] OFS_CAUSE2 = 8'h04;
  localparam logic [7:0] OFS_POL = 8'h08;
  localparam logic [7:0] OFS_MEN1 = 8'h0C;
  localparam logic [7:0] OFS_MEN2 = 8'h10;
  localparam logic [7:0] OFS_MADDR0 = 8'h14;
  localparam logic [7:0] OFS_MADDR_STEP = 8'h04;
  localparam logic [7:0] OFS_PEND = 8'h24;
  localparam logic [7:0] OFS_STAT = 8'h28;
  localparam logic [7:0] OFS_KDIR = 8'h2C;
  // field positions
  localparam int EXT4_ROUTE_BIT = 6;
  localparam int EXT5_ROUTE_BIT = 7;
  localparam int COLL0_ROUTE_BIT = 6;
  localparam int COLL1_ROUTE_BIT = 7;
  localparam int PEND_EXT_LSB = 0;
  localparam int PEND_NMI_BIT = 6;
  localparam int PEND_KEY_BIT = 7;
  localparam int PEND_MATCH_BIT = 8;
  localparam int PEND_W = 9;
  localparam int STAT_NMI_BIT = 0;
  localparam int STAT_KEY_LSB = 1;
  localparam int STAT_KEYLOW_BIT = 5;
  // reset values
  localparam logic [7:0] RST_CAUSE = 8'h00;
  localparam logic [7:0] RST_CAUSE2 = 8'h00;
  localparam logic [5:0] RST_POL = 6'h00;
  localparam logic [1:0] RST_MEN = 2'h0;
  localparam logic [19:0] RST_MADDR = 20'h00000;
  localparam logic [3:0] RST_KDIR = 4'h0;
  // stacked pc offsets after a match
  localparam logic [19:0] PC_OFS_SHORT = 20'h00002;
  localparam logic [19:0] PC_OFS_OTHER = 20'h00001;
endpackage

//--- hw/irqfe_edge.sv
// two-flop synchroniser with edge detection for a group of pins
`timescale 1ns/1ps
`default_nettype none
module irqfe_edge #(
  parameter int W = 1,
  parameter logic [W-1:0] IDLE = '1
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // idle reset value keeps a false edge away at reset release
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_q <= IDLE;
      sync_q <= IDLE;
      prev_q <= IDLE;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // compare successive sampled levels
  assign level = sync_q;
  assign rise = sync_q & ~prev_q; // R22
  assign fall = ~sync_q & prev_q; // R22
endmodule // irqfe_edge
`default_nettype wire

//--- hw/irqfe_match.sv
// address comparators raising a request before a chosen instruction
`timescale 1ns/1ps
`default_nettype none
module irqfe_match
  import irqfe_pkg::*;
#(
  parameter int N = MATCH_N
) (
  input wire logic [N-1:0] enable,
  input wire logic [N*ADDR_W-1:0] match_addr,
  input wire logic fetch_start,
  input wire logic [ADDR_W-1:0] fetch_addr,
  input wire logic fetch_external,
  input wire logic fetch_short_op,
  input wire logic ext_bus_8bit,
  output logic hit,
  output logic [1:0] unit,
  output logic [ADDR_W-1:0] return_pc
);
  logic [ADDR_W-1:0] sel_addr;

  // lowest unit wins when two registers hold the same address
  always_comb begin
    hit = 1'b0;
    unit = 2'h0;
    sel_addr = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (enable[i] && fetch_addr == match_addr[i*ADDR_W +: ADDR_W]) begin
        hit = 1'b1; // R15
        unit = i[1:0];
        sel_addr = match_addr[i*ADDR_W +: ADDR_W];
      end
    end
    // no detection on external areas of an 8-bit bus
    if (!fetch_start || (fetch_external && ext_bus_8bit)) begin // R19
      hit = 1'b0;
    end
  end

  // stacked pc is not the true return address
  assign return_pc = sel_addr +
    (fetch_short_op ? PC_OFS_SHORT : PC_OFS_OTHER); // R18
endmodule // irqfe_match
`default_nettype wire

//--- hw/irqfe_top.sv
// interrupt source front end: pin edges, nmi, key input, address match
// How it works
// R1: each of six pin interrupts fires on an edge of chosen polarity.
// R2: route bits pick pin four/five, else serial three/four, for shared vectors.
// R3: software clears the pending flag after changing a route bit.
// R4: software keeps polarity falling when both edges are selected.
// R5: software keeps route bits at serial in expansion and processor modes.
// R6: software keeps serial polarity falling when serial channels are routed.
// R7: collision0 route bit picks timer B3/hsync at 0, uart0 collision at 1.
// R8: collision1 route bit picks timer B4/remote at 0, uart1 collision at 1.
// R9: high-to-low on the nmi pin always raises the nmi, unmasked.
// R10: nmi pin level is readable in status but is no input port.
// R11: a key pin set as input going low raises the key interrupt.
// R12: the key interrupt also wakes the device from wait or stop.
// R13: while one key pin is held low other key falls are ignored.
// R14: software must not use key pins as analog inputs.
// R15: four match units request just before the matching instruction runs.
// R16: units 0,1 enabled by first enable register, 2,3 by second.
// R17: match requests ignore global enable and processor priority level.
// R18: stacked pc is match address plus two for short opcodes, else one.
// R19: no match detection on external areas with an 8-bit bus.
// R20: handler must patch stack and return, or unwind and jump.
// R21: software writes only instruction start addresses as match addresses.
// R22: pins are synchronised and edge detected from successive samples.
`timescale 1ns/1ps
`default_nettype none
module irqfe_top (
  input wire logic clock,
  input wire logic rstn,
  // apb slave
  input wire logic [irqfe_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic [irqfe_pkg::EXT_N-1:0] ext_edge_irq,
  input wire logic nmi_n,
  input wire logic [irqfe_pkg::KEY_N-1:0] key_pin,
  // on-chip sources sharing vectors
  input wire logic serial3_req,
  input wire logic serial4_req,
  input wire logic timer_b3_req,
  input wire logic collision0_req,
  input wire logic timer_b4_req,
  input wire logic collision1_req,
  // core fetch view
  input wire logic fetch_start,
  input wire logic [irqfe_pkg::ADDR_W-1:0] fetch_addr,
  input wire logic fetch_external,
  input wire logic fetch_short_op,
  input wire logic ext_bus_8bit,
  // requests towards the priority resolver
  output logic [3:0] ext_req,
  output logic shared4_req,
  output logic shared5_req,
  output logic tb3_vec_req,
  output logic tb4_vec_req,
  output logic nmi_req,
  output logic key_req,
  output logic key_wake,
  output logic match_req,
  output logic [1:0] match_unit,
  output logic [irqfe_pkg::ADDR_W-1:0] match_return_pc
);
  import irqfe_pkg::*;

  // pick the active edge for one input
  function automatic logic edge_pick(input logic rise, input logic fall,
                                     input logic both, input logic edge_polarity_bit);
    if (both) begin
      return rise | fall;
    end
    return edge_polarity_bit ? rise : fall;
  endfunction

  // byte address of match address register n; read and write share it
  function automatic logic maddr_at(input logic [APB_AW-1:0] addr,
                                    input int n);
    return addr == OFS_MADDR0 + 8'(n) * OFS_MADDR_STEP;
  endfunction

  logic [7:0] cause_q;
  logic [7:0] cause2_q;
  logic [5:0] pol_q;
  logic [1:0] men1_q;
  logic [1:0] men2_q;
  logic [MATCH_N*ADDR_W-1:0] maddr_q;
  logic [KEY_N-1:0] kdir_q;
  logic [PEND_W-1:0] pend_q;
  logic [PEND_W-1:0] pend_set;
  logic key_low_q;
  logic [EXT_N-1:0] ext_lvl;
  logic [EXT_N-1:0] ext_rise;
  logic [EXT_N-1:0] ext_fall;
  logic [EXT_N-1:0] ext_ev;
  logic nmi_lvl;
  logic nmi_fall;
  logic [KEY_N-1:0] key_lvl;
  logic key_low;
  logic key_ev;
  logic m_hit;
  logic [1:0] m_unit;
  logic [ADDR_W-1:0] m_pc;
  logic acc;
  logic wr_en;
  logic mapped;
  logic [31:0] rd_word;

  // pin synchronisers; idle level is high for all pins
  irqfe_edge #(.W(EXT_N), .IDLE('1)) u_ext (
    .clock(clock),
    .rstn(rstn),
    .pin(ext_edge_irq),
    .level(ext_lvl),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  irqfe_edge #(.W(1), .IDLE(1'b1)) u_nmi (
    .clock(clock),
    .rstn(rstn),
    .pin(nmi_n),
    .level(nmi_lvl),
    .rise(),
    .fall(nmi_fall)
  );

  irqfe_edge #(.W(KEY_N), .IDLE('1)) u_key (
    .clock(clock),
    .rstn(rstn),
    .pin(key_pin),
    .level(key_lvl),
    .rise(),
    .fall()
  );

  // enables of both registers feed one comparator bank
  irqfe_match #(.N(MATCH_N)) u_match (
    .enable({men2_q, men1_q}), // R16
    .match_addr(maddr_q),
    .fetch_start(fetch_start),
    .fetch_addr(fetch_addr),
    .fetch_external(fetch_external),
    .fetch_short_op(fetch_short_op),
    .ext_bus_8bit(ext_bus_8bit),
    .hit(m_hit),
    .unit(m_unit),
    .return_pc(m_pc)
  );

  // edge events per pin; both-edge bit overrides polarity
  always_comb begin
    for (int i = 0; i < EXT_N; i++) begin
      ext_ev[i] = edge_pick(ext_rise[i], ext_fall[i], cause_q[i],
                            pol_q[i]); // R1
    end
  end

  // only input-configured pins count; a new low while another is
  // already low does not make a fresh event
  assign key_low = |(~key_lvl & ~kdir_q); // R11
  assign key_ev = key_low & ~key_low_q; // R13

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      key_low_q <= 1'b0;
    end else begin
      key_low_q <= key_low;
    end
  end

  // registered requests towards the core; pin events pulse one cycle, peripheral requests keep their length
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ext_req <= 4'h0;
      shared4_req <= 1'b0;
      shared5_req <= 1'b0;
      tb3_vec_req <= 1'b0;
      tb4_vec_req <= 1'b0;
    end else begin
      ext_req <= ext_ev[3:0];
      shared4_req <= cause_q[EXT4_ROUTE_BIT] ? ext_ev[4]
                                              : serial3_req; // R2
      shared5_req <= cause_q[EXT5_ROUTE_BIT] ? ext_ev[5]
                                              : serial4_req; // R2
      tb3_vec_req <= cause2_q[COLL0_ROUTE_BIT] ? collision0_req
                                                : timer_b3_req; // R7
      tb4_vec_req <= cause2_q[COLL1_ROUTE_BIT] ? collision1_req
                                                : timer_b4_req; // R8
    end
  end

  // nmi and key outputs; nothing here can mask them
  // wake is a pulse, so the clock must still run in the low-power modes
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      nmi_req <= 1'b0;
      key_req <= 1'b0;
      key_wake <= 1'b0;
    end else begin
      nmi_req <= nmi_fall; // R9
      key_req <= key_ev; // R11
      key_wake <= key_ev; // R12
    end
  end

  // match request is not gated by any enable flag or level here
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      match_req <= 1'b0;
      match_unit <= 2'h0;
      match_return_pc <= '0;
    end else begin
      match_req <= m_hit; // R17
      if (m_hit) begin
        match_unit <= m_unit;
        match_return_pc <= m_pc; // R18
      end
    end
  end

  // apb: answer one cycle into the access phase
  // one fixed wait state keeps the decode off the critical path
  assign acc = psel & penable;
  assign wr_en = acc & pready & pwrite & mapped;

  always_comb begin
    mapped = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (paddr)
      OFS_CAUSE: rd_word[7:0] = cause_q;
      OFS_CAUSE2: rd_word[7:0] = cause2_q;
      OFS_POL: rd_word[5:0] = pol_q;
      OFS_MEN1: rd_word[1:0] = men1_q;
      OFS_MEN2: rd_word[1:0] = men2_q;
      OFS_PEND: rd_word[PEND_W-1:0] = pend_q;
      OFS_KDIR: rd_word[KEY_N-1:0] = kdir_q;
      OFS_STAT: begin
        rd_word[STAT_NMI_BIT] = nmi_lvl; // R10
        rd_word[STAT_KEY_LSB +: KEY_N] = key_lvl;
        rd_word[STAT_KEYLOW_BIT] = key_low_q;
      end
      default: begin
        mapped = 1'b0;
        for (int i = 0; i < MATCH_N; i++) begin
          if (maddr_at(paddr, i)) begin
            mapped = 1'b1;
            rd_word[ADDR_W-1:0] = maddr_q[i*ADDR_W +: ADDR_W];
          end
        end
      end
    endcase
  end

  // pready high for one cycle; read data and error stand with it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      prdata <= (acc & ~pready & ~pwrite) ? rd_word : 32'h0000_0000;
    end
  end

  // source routing; a route change leaves stale pending flags behind,
  // which software has to clear itself
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cause_q <= RST_CAUSE;
      cause2_q <= RST_CAUSE2;
    end else if (wr_en) begin
      if (paddr == OFS_CAUSE) begin
        cause_q <= pwdata[7:0]; // R2
      end
      if (paddr == OFS_CAUSE2) begin
        cause2_q <= pwdata[7:0]; // R7
      end
    end
  end

  // pin polarity and key direction
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pol_q <= RST_POL;
      kdir_q <= RST_KDIR;
    end else if (wr_en) begin
      if (paddr == OFS_POL) begin
        pol_q <= pwdata[5:0]; // R1
      end
      if (paddr == OFS_KDIR) begin
        kdir_q <= pwdata[KEY_N-1:0]; // R11
      end
    end
  end

  // match enables and addresses
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      men1_q <= RST_MEN;
      men2_q <= RST_MEN;
      maddr_q <= {MATCH_N{RST_MADDR}};
    end else if (wr_en) begin
      if (paddr == OFS_MEN1) begin
        men1_q <= pwdata[1:0]; // R16
      end
      if (paddr == OFS_MEN2) begin
        men2_q <= pwdata[1:0]; // R16
      end
      for (int i = 0; i < MATCH_N; i++) begin
        if (maddr_at(paddr, i)) begin
          maddr_q[i*ADDR_W +: ADDR_W] <= pwdata[ADDR_W-1:0];
        end
      end
    end
  end

  // sticky event flags for software; an event in the clearing cycle
  // survives because the set term is applied after the clear
  always_comb begin
    pend_set = '0;
    pend_set[PEND_EXT_LSB +: EXT_N] = ext_ev;
    pend_set[PEND_NMI_BIT] = nmi_fall;
    pend_set[PEND_KEY_BIT] = key_ev;
    pend_set[PEND_MATCH_BIT] = m_hit;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pend_q <= '0;
    end else if (wr_en && paddr == OFS_PEND) begin
      pend_q <= (pend_q & ~pwdata[PEND_W-1:0]) | pend_set;
    end else begin
      pend_q <= pend_q | pend_set;
    end
  end
endmodule // irqfe_top
`default_nettype wire

//--- tb/irqfe_asserts.sv
// concurrent checks on the front end ports
`timescale 1ns/1ps
`default_nettype none
module irqfe_asserts (
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic nmi_n,
  input wire logic [3:0] key_pin,
  input wire logic timer_b3_req,
  input wire logic collision0_req,
  input wire logic fetch_start,
  input wire logic [19:0] fetch_addr,
  input wire logic fetch_external,
  input wire logic fetch_short_op,
  input wire logic ext_bus_8bit,
  input wire logic tb3_vec_req,
  input wire logic nmi_req,
  input wire logic key_req,
  input wire logic key_wake,
  input wire logic match_req,
  input wire logic [19:0] match_return_pc
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // first access cycle of a transfer
  sequence s_access;
    psel && penable && !pready && !$past(penable);
  endsequence
  property p_wait;
    s_access |=> pready;
  endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pready held");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("pslverr alone");
  // synchroniser delay bounds the nmi answer
  property p_nmi;
    $fell(nmi_n) |-> ##[1:4] nmi_req;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi lost");
  property p_pc;
    match_req |-> $past(fetch_start) && match_return_pc == $past(fetch_addr)
      + ($past(fetch_short_op) ? 20'h00002 : 20'h00001);
  endproperty
  a_pc: assert property (p_pc) else $error("bad return pc");
  property p_hold;
    !match_req |-> $stable(match_return_pc);
  endproperty
  a_hold: assert property (p_hold) else $error("pc moved");
  property p_narrow;
    fetch_start && fetch_external && ext_bus_8bit |=> !match_req;
  endproperty
  a_narrow: assert property (p_narrow) else $error("8-bit match");
  property p_wake;
    key_wake == key_req && (!key_wake || $past(key_pin, 3) != 4'hF);
  endproperty
  a_wake: assert property (p_wake) else $error("wake differs");
  // a key already low masks later falls
  property p_key;
    (key_pin != 4'hF) [*6] |-> !key_req;
  endproperty
  a_key: assert property (p_key) else $error("key refired");
  property p_tb3;
    tb3_vec_req |-> $past(timer_b3_req || collision0_req);
  endproperty
  a_tb3: assert property (p_tb3) else $error("tb3 no cause");
endmodule // irqfe_asserts
bind irqfe_top irqfe_asserts u_chk (.clock, .rstn, .psel, .penable, .pready,
  .pslverr, .nmi_n, .key_pin, .timer_b3_req, .collision0_req, .fetch_start,
  .fetch_addr, .fetch_external, .fetch_short_op, .ext_bus_8bit,
  .tb3_vec_req, .nmi_req, .key_req, .key_wake, .match_req,
  .match_return_pc);
`default_nettype wire

//--- tb/irqfe_far.sv
// pins, peripherals and core fetch on the far side
`timescale 1ns/1ps
`default_nettype none
module irqfe_far (
  input wire logic clock,
  output logic [5:0] ext_edge_irq,
  output logic nmi_n,
  output logic [3:0] key_pin,
  output logic [5:0] periph,
  output logic fetch_start,
  output logic [19:0] fetch_addr,
  output logic fetch_external,
  output logic fetch_short_op,
  output logic ext_bus_8bit
);
  // pins idle high so reset release gives no event
  initial begin
    ext_edge_irq = 6'h3F;
    nmi_n = 1'b1;
    key_pin = 4'hF;
    periph = 6'h00;
    fetch_start = 1'b0;
    fetch_addr = 20'h00000;
    {fetch_external, fetch_short_op, ext_bus_8bit} = 3'h0;
  end
  // key pins stay digital levels only
  task pins(input logic [5:0] e, input logic n, input logic [3:0] k);
    @(posedge clock);
    ext_edge_irq <= e;
    nmi_n <= n;
    key_pin <= k;
    repeat (8) @(posedge clock);
  endtask
  task pulse(input logic [5:0] r);
    @(posedge clock) periph <= r;
    @(posedge clock) periph <= 6'h00;
    repeat (3) @(posedge clock);
  endtask
  // addresses are instruction starts; released bus shows inverse
  task fetch(input logic [19:0] a, input logic x, s, b);
    @(posedge clock) fetch_start <= 1'b1;
    fetch_addr <= a;
    {fetch_external, fetch_short_op, ext_bus_8bit} <= {x, s, b};
    @(posedge clock) fetch_start <= 1'b0;
    fetch_addr <= ~a;
    repeat (3) @(posedge clock);
  endtask
endmodule // irqfe_far
`default_nettype wire

//--- tb/irq_source_frontend_test.sv
// self-checking bench for the interrupt source front end
`timescale 1ns/1ps
`default_nettype none
module irq_source_frontend_test;
  import irqfe_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000, prdata, r;
  logic pready, pslverr, nmi_n, fetch_start, fetch_external;
  logic fetch_short_op, ext_bus_8bit, shared4_req, shared5_req;
  logic tb3_vec_req, tb4_vec_req, nmi_req, key_req, key_wake, match_req;
  logic [5:0] ext_edge_irq, periph;
  logic [3:0] key_pin, ext_req;
  logic [19:0] fetch_addr, match_return_pc, ma;
  logic [1:0] match_unit;
  logic [9:0] ev;
  logic [32:0] rq[$];
  logic [21:0] mq[$];
  logic [31:0] msk[12] = '{32'hFF, 32'hFF, 32'h3F, 32'h3, 32'h3, 32'hFFFFF,
    32'hFFFFF, 32'hFFFFF, 32'hFFFFF, 32'h0, 32'h0, 32'hF};
  int miscompares = 0, check_count = 0, seed = 60;
  int cnt[10] = '{default: 0}, want[10] = '{default: 0};
  always #5 clock = ~clock;
  assign ev = {key_req, nmi_req, tb4_vec_req, tb3_vec_req, shared5_req,
    shared4_req, ext_req};
  irqfe_top uut (.clock, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .ext_edge_irq, .nmi_n, .key_pin,
    .serial3_req(periph[0]), .serial4_req(periph[1]),
    .timer_b3_req(periph[2]), .collision0_req(periph[3]),
    .timer_b4_req(periph[4]), .collision1_req(periph[5]), .fetch_start,
    .fetch_addr, .fetch_external, .fetch_short_op, .ext_bus_8bit, .ext_req,
    .shared4_req, .shared5_req, .tb3_vec_req, .tb4_vec_req, .nmi_req,
    .key_req, .key_wake, .match_req, .match_unit, .match_return_pc);
  irqfe_far far (.clock, .ext_edge_irq, .nmi_n, .key_pin, .periph,
    .fetch_start, .fetch_addr, .fetch_external, .fetch_short_op,
    .ext_bus_8bit);
  task check(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one transfer; a gap cycle keeps back-to-back calls race free
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock) psel <= 1'b1;
    {penable, pwrite, paddr, pwdata} <= {1'b0, w, a, d};
    @(posedge clock) penable <= 1'b1;
    // pready is taken at a rising edge; the request stands until then
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    {psel, penable} <= 2'b00;
    pwdata <= ~d;
  endtask
  task rd(input logic [7:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task tally;
    for (int i = 0; i < 10; i++) check(33'(cnt[i]), 33'(want[i]));
  endtask
  // watcher: reads and matches pop the oldest note, requests are counted
  always @(negedge clock) begin
    if (pready === 1'b1 && pwrite === 1'b0)
      check({pslverr, prdata}, rq.pop_front());
    if (match_req === 1'b1)
      check({match_unit, match_return_pc}, mq.pop_front());
    for (int i = 0; i < 10; i++) if (ev[i] === 1'b1) cnt[i]++;
  end
  // hang guard well beyond the planned run
  initial begin
    #200000;
    miscompares++;
    close_out;
  end
  initial begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < 12; i++) if (msk[i] != 0) begin
      r = $random(seed);
      rd(8'(4 * i), 33'h0);
      apb(1'b1, 8'(4 * i), r);
      rd(8'(4 * i), {1'b0, r & msk[i]});
      apb(1'b1, 8'(4 * i), 32'h0);
    end
    rd(OFS_STAT, 33'h1F);
    rd(8'h30, {1'b1, 32'h0});
    // each polarity mode, pins four and five routed
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, OFS_CAUSE, (m == 2) ? 32'hFF : 32'hC0);
      apb(1'b1, OFS_POL, (m == 1) ? 32'h3F : 32'h0);
      apb(1'b1, OFS_PEND, 32'h1FF);
      far.pins(6'h00, 1'b1, 4'hF);
      far.pins(6'h3F, 1'b1, 4'hF);
      for (int i = 0; i < 6; i++) want[i] += (m == 2) ? 2 : 1;
      tally();
    end
    apb(1'b1, OFS_CAUSE, 32'h0);
    apb(1'b1, OFS_PEND, 32'h1FF);
    far.pins(6'h0F, 1'b1, 4'hF);
    far.pins(6'h3F, 1'b1, 4'hF);
    far.pulse(6'h17);
    for (int i = 4; i < 8; i++) want[i]++;
    apb(1'b1, OFS_CAUSE2, 32'hC0);
    far.pulse(6'h28);
    far.pulse(6'h14);
    want[6]++;
    want[7]++;
    tally();
    far.pins(6'h3F, 1'b0, 4'hF);
    want[8]++;
    rd(OFS_STAT, 33'h1E);
    far.pins(6'h3F, 1'b1, 4'hE);
    far.pins(6'h3F, 1'b1, 4'hC);
    far.pins(6'h3F, 1'b1, 4'hF);
    want[9]++;
    apb(1'b1, OFS_KDIR, 32'h4);
    far.pins(6'h3F, 1'b1, 4'hB);
    far.pins(6'h3F, 1'b1, 4'hF);
    tally();
    rd(OFS_PEND, 33'h0F0);
    apb(1'b1, OFS_PEND, 32'h30);
    rd(OFS_PEND, 33'h0C0);
    ma = 20'($random(seed));
    apb(1'b1, OFS_MADDR0 + 8'h08, 32'(ma));
    apb(1'b1, OFS_MEN2, 32'h1);
    // stacked pc is off on purpose; the handler patches it from this
    mq.push_back({2'd2, ma + 20'h00001});
    far.fetch(ma, 1'b0, 1'b0, 1'b0);
    mq.push_back({2'd2, ma + 20'h00002});
    far.fetch(ma, 1'b0, 1'b1, 1'b0);
    far.fetch(ma, 1'b1, 1'b0, 1'b1);
    mq.push_back({2'd2, ma + 20'h00001});
    far.fetch(ma, 1'b1, 1'b0, 1'b0);
    apb(1'b1, OFS_MEN2, 32'h0);
    apb(1'b1, OFS_MADDR0, 32'(ma));
    apb(1'b1, OFS_MEN1, 32'h1);
    mq.push_back({2'd0, ma + 20'h00002});
    far.fetch(ma, 1'b0, 1'b1, 1'b0);
    check(33'(mq.size()), 33'h0);
    rd(OFS_PEND, 33'h1C0);
    close_out;
  end
endmodule // irq_source_frontend_test
`default_nettype wire
